// ==== pupd_pkg.sv ====
package pupd_pkg;
	localparam int          LIST_MAX     = 64;
	localparam int          IDX_W        = 6;
	localparam int          CNT_W        = 7;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          NREG         = 256;
	localparam logic [31:0] REG_RESET    = 32'h0000_0000;
	localparam logic [6:0]  LIST_EMPTY   = 7'h00;
	localparam logic [1:0]  DELAY_QUICK  = 2'h1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pupd_entry_t;

	typedef enum logic [2:0] {
		PUPD_IDLE  = 3'b000,
		PUPD_LOAD  = 3'b001,
		PUPD_APPLY = 3'b010,
		PUPD_COPY  = 3'b011
	} pupd_state_t;
endpackage

// ==== pupd_list_mem.sv ====
`timescale 1ns/1ps
module pupd_list_mem
	import pupd_pkg::*;
(
	// clock
	input  wire logic                    clk,
	// write side
	input  wire logic                    we,
	input  wire logic [IDX_W-1:0]        waddr,
	input  wire pupd_pkg::pupd_entry_t   wdata,
	// read side, registered data
	input  wire logic [IDX_W-1:0]        raddr,
	output pupd_pkg::pupd_entry_t        rdata
);
	pupd_entry_t mem [LIST_MAX];

	// no reset on the array, contents are only read after being written
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ==== pupd_core.sv ====
`timescale 1ns/1ps
module pupd_core
	import pupd_pkg::*;
(
	// clock and reset
	input  wire logic                  MCLK,
	input  wire logic                  RST,
	// mode select
	input  wire logic                  QUICK_CHANGE_MODE,
	// single parameter write
	input  wire logic                  SINGLE_VALID,
	input  wire pupd_pkg::pupd_entry_t SINGLE_ENTRY,
	// block list write
	input  wire logic                  LIST_VALID,
	input  wire logic                  LIST_LAST,
	input  wire pupd_pkg::pupd_entry_t LIST_ENTRY,
	output logic                       LIST_READY,
	// frame timing from capture logic
	input  wire logic                  FRAME_START,
	input  wire logic                  EXPOSING,
	input  wire logic                  TRANSFERRING,
	// register port toward capture logic
	output logic                       ACT_WE,
	output pupd_pkg::pupd_entry_t      ACT_ENTRY,
	output logic                       ACT_COMMIT,
	output logic                       EXPOSE_HOLD,
	output logic                       EXPOSE_ABORT,
	output logic                       DROP_IMAGE,
	output logic                       LIST_OVERFLOW
);
	pupd_state_t       state_q, state_d;
	logic [CNT_W-1:0]  wcnt_q, wcnt_d;
	logic [IDX_W-1:0]  ridx_q, ridx_d;
	logic              single_pend_q, single_pend_d;
	pupd_entry_t       single_q, single_d;
	logic              we_q, we_d;
	pupd_entry_t       act_q, act_d;
	logic              commit_q, commit_d;
	logic              abort_q, abort_d;
	logic              drop_q, drop_d;
	logic              ovf_q, ovf_d;
	logic              mem_we;
	logic [IDX_W-1:0]  mem_raddr;
	pupd_entry_t       mem_rdata;
	logic              apply_ok;

	// staging store: list is gathered here, capture side keeps old set meanwhile
	pupd_list_mem u_mem (
		.clk   (MCLK),
		.we    (mem_we),
		.waddr (wcnt_q[IDX_W-1:0]),
		.wdata (LIST_ENTRY),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	assign LIST_READY = (state_q == PUPD_IDLE) || (state_q == PUPD_LOAD);
	assign mem_we     = LIST_VALID && LIST_READY && (wcnt_q < CNT_W'(LIST_MAX));
	assign mem_raddr  = ridx_d;
	// standard waits for a frame boundary; quick needs no boundary, only the transfer gate below
	assign apply_ok   = QUICK_CHANGE_MODE || FRAME_START;

	always_comb begin
		state_d       = state_q;
		wcnt_d        = wcnt_q;
		ridx_d        = ridx_q;
		single_pend_d = single_pend_q;
		single_d      = single_q;
		we_d          = 1'b0;
		act_d         = act_q;
		commit_d      = 1'b0;
		abort_d       = 1'b0;
		drop_d        = 1'b0;
		ovf_d         = ovf_q;
		// latest single write overwrites a pending one, no queue
		if (SINGLE_VALID) begin
			single_pend_d = 1'b1;
			single_d      = SINGLE_ENTRY;
		end
		unique case (state_q)
			PUPD_IDLE, PUPD_LOAD: begin
				if (LIST_VALID) begin
					state_d = PUPD_LOAD;
					if (wcnt_q < CNT_W'(LIST_MAX)) begin
						wcnt_d = wcnt_q + CNT_W'(1);
					end else begin
						ovf_d = 1'b1;
					end
					if (LIST_LAST) begin
						state_d = PUPD_APPLY;
					end
				end else if (state_q == PUPD_IDLE && single_pend_q && !SINGLE_VALID
					&& apply_ok && !(QUICK_CHANGE_MODE && TRANSFERRING)) begin
					we_d          = 1'b1;
					act_d         = single_q;
					commit_d      = 1'b1;
					single_pend_d = 1'b0;
					// quick: exposure restarted, half-exposed image dropped
					abort_d = QUICK_CHANGE_MODE && EXPOSING;
					drop_d  = QUICK_CHANGE_MODE && EXPOSING;
				end
			end
			PUPD_APPLY: begin
				// standard waits for a boundary; quick mode waits only for the transfer to end
				if (apply_ok && !(QUICK_CHANGE_MODE && TRANSFERRING)) begin
					state_d = PUPD_COPY;
					ridx_d  = '0;
					abort_d = QUICK_CHANGE_MODE && EXPOSING;
					drop_d  = QUICK_CHANGE_MODE && EXPOSING;
				end
			end
			PUPD_COPY: begin
				// in order, so a later same-address entry wins
				we_d  = 1'b1;
				act_d = mem_rdata;
				if ({1'b0, ridx_q} + CNT_W'(1) >= wcnt_q) begin
					commit_d = 1'b1;
					wcnt_d   = LIST_EMPTY;
					state_d  = PUPD_IDLE;
				end else begin
					ridx_d = ridx_q + IDX_W'(1);
				end
			end
			default: state_d = PUPD_IDLE;
		endcase
		if (state_q == PUPD_IDLE && wcnt_q == LIST_EMPTY && LIST_VALID) begin
			ovf_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q       <= PUPD_IDLE;
			wcnt_q        <= LIST_EMPTY;
			ridx_q        <= '0;
			single_pend_q <= 1'b0;
			single_q      <= '0;
			we_q          <= 1'b0;
			act_q         <= '0;
			commit_q      <= 1'b0;
			abort_q       <= 1'b0;
			drop_q        <= 1'b0;
			ovf_q         <= 1'b0;
		end else begin
			state_q       <= state_d;
			wcnt_q        <= wcnt_d;
			ridx_q        <= ridx_d;
			single_pend_q <= single_pend_d;
			single_q      <= single_d;
			we_q          <= we_d;
			act_q         <= act_d;
			commit_q      <= commit_d;
			abort_q       <= abort_d;
			drop_q        <= drop_d;
			ovf_q         <= ovf_d;
		end
	end

	assign ACT_WE        = we_q;
	assign ACT_ENTRY     = act_q;
	assign ACT_COMMIT    = commit_q;
	assign EXPOSE_ABORT  = abort_q;
	assign DROP_IMAGE    = drop_q;
	assign LIST_OVERFLOW = ovf_q;
	// quick mode blocks new exposure until the list is in
	assign EXPOSE_HOLD   = QUICK_CHANGE_MODE && (state_q != PUPD_IDLE);

	a_list_bound: assert property (@(posedge MCLK) disable iff (RST)
		wcnt_q <= CNT_W'(LIST_MAX)) else $error("list count above limit");
	a_std_boundary: assert property (@(posedge MCLK) disable iff (RST)
		(state_q == PUPD_APPLY && !QUICK_CHANGE_MODE && !FRAME_START)
		|=> state_q == PUPD_APPLY) else $error("standard list left wait early");
	a_commit_once: assert property (@(posedge MCLK) disable iff (RST)
		(state_q == PUPD_COPY && state_d == PUPD_IDLE) |=> ACT_COMMIT && ACT_WE)
		else $error("list commit missing");
	a_no_commit_mid: assert property (@(posedge MCLK) disable iff (RST)
		(state_q == PUPD_COPY && state_d == PUPD_COPY) |=> !ACT_COMMIT)
		else $error("commit inside list");
	a_quick_hold: assert property (@(posedge MCLK) disable iff (RST)
		(QUICK_CHANGE_MODE && state_q == PUPD_APPLY) |-> EXPOSE_HOLD)
		else $error("exposure not held");
	a_no_abort_std: assert property (@(posedge MCLK) disable iff (RST)
		!$past(QUICK_CHANGE_MODE) |-> !EXPOSE_ABORT) else $error("abort in standard");
	a_quick_single: assert property (@(posedge MCLK) disable iff (RST)
		(QUICK_CHANGE_MODE && state_q == PUPD_IDLE && single_pend_q && !SINGLE_VALID
		&& !LIST_VALID && !TRANSFERRING) |=> ACT_COMMIT) else $error("quick late");
	a_transfer_safe: assert property (@(posedge MCLK) disable iff (RST)
		(QUICK_CHANGE_MODE && TRANSFERRING && state_q != PUPD_COPY) |=> !ACT_WE)
		else $error("update during transfer");
	a_drop_pairs: assert property (@(posedge MCLK) disable iff (RST)
		DROP_IMAGE |-> EXPOSE_ABORT) else $error("drop without abort");
	a_std_single_gate: assert property (@(posedge MCLK) disable iff (RST)
		(!QUICK_CHANGE_MODE && !FRAME_START && state_q == PUPD_IDLE) |=> !ACT_WE)
		else $error("standard update off boundary");
	a_no_drop_std: assert property (@(posedge MCLK) disable iff (RST)
		!$past(QUICK_CHANGE_MODE) |-> !DROP_IMAGE)
		else $error("drop in standard");
	// capture keeps the old set while the list waits for its slot
	a_old_set_kept: assert property (@(posedge MCLK) disable iff (RST)
		(state_q == PUPD_APPLY) |=> !ACT_WE)
		else $error("entry written before copy");
	a_commit_idle: assert property (@(posedge MCLK) disable iff (RST)
		ACT_COMMIT |-> state_q == PUPD_IDLE)
		else $error("commit before list done");
endmodule

// ==== pupd_host.sv ====
`timescale 1ns/1ps
module pupd_host
	import pupd_pkg::*;
(
	// clock and flow control
	input  wire logic             MCLK,
	input  wire logic             LIST_READY,
	// writes toward the block
	output logic                  LIST_VALID,
	output logic                  LIST_LAST,
	output pupd_pkg::pupd_entry_t LIST_ENTRY,
	output logic                  SINGLE_VALID,
	output pupd_pkg::pupd_entry_t SINGLE_ENTRY
);
	initial begin
		LIST_VALID = 1'b0;
		LIST_LAST = 1'b0;
		LIST_ENTRY = '0;
		SINGLE_VALID = 1'b0;
		SINGLE_ENTRY = '0;
	end
	// whole list as one burst, never split into singles
	task automatic send_list(input int n, input logic [7:0] a0, output bit ok);
		int t;
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			LIST_VALID = 1'b1;
			LIST_LAST = (i == n - 1);
			LIST_ENTRY = {a0 + 8'(i), 32'h0000_a000 + 32'(i)};
			t = 0;
			while (LIST_READY !== 1'b1 && t < 50) begin
				@(posedge MCLK);
				#2;
				t++;
			end
			if (t == 50) ok = 1'b0;
			@(posedge MCLK);
			#2;
		end
		LIST_VALID = 1'b0;
		LIST_LAST = 1'b0;
		// released bus shows no stale entry
		LIST_ENTRY = ~LIST_ENTRY;
	endtask
	task automatic send_single(input logic [7:0] a, input logic [31:0] d);
		SINGLE_VALID = 1'b1;
		SINGLE_ENTRY = {a, d};
		@(posedge MCLK);
		#2;
		SINGLE_VALID = 1'b0;
		SINGLE_ENTRY = ~SINGLE_ENTRY;
	endtask
endmodule

// ==== test_parameter_update_timing.sv ====
`timescale 1ns/1ps
module test_parameter_update_timing;
	import pupd_pkg::*;
	logic        MCLK, RST, QUICK_CHANGE_MODE, FRAME_START, EXPOSING, TRANSFERRING;
	logic        SINGLE_VALID, LIST_VALID, LIST_LAST, LIST_READY, ACT_WE, ACT_COMMIT;
	logic        EXPOSE_HOLD, EXPOSE_ABORT, DROP_IMAGE, LIST_OVERFLOW;
	pupd_entry_t SINGLE_ENTRY, LIST_ENTRY, ACT_ENTRY;
	pupd_entry_t got[$];
	int          n_mismatch, checks_done, n_commit, n_abort, n_drop;
	bit          ok;
	pupd_core u_pupd_core (.MCLK(MCLK), .RST(RST), .QUICK_CHANGE_MODE(QUICK_CHANGE_MODE),
		.SINGLE_VALID(SINGLE_VALID), .SINGLE_ENTRY(SINGLE_ENTRY), .LIST_VALID(LIST_VALID),
		.LIST_LAST(LIST_LAST), .LIST_ENTRY(LIST_ENTRY), .LIST_READY(LIST_READY),
		.FRAME_START(FRAME_START), .EXPOSING(EXPOSING), .TRANSFERRING(TRANSFERRING),
		.ACT_WE(ACT_WE), .ACT_ENTRY(ACT_ENTRY), .ACT_COMMIT(ACT_COMMIT),
		.EXPOSE_HOLD(EXPOSE_HOLD), .EXPOSE_ABORT(EXPOSE_ABORT), .DROP_IMAGE(DROP_IMAGE),
		.LIST_OVERFLOW(LIST_OVERFLOW));
	pupd_host u_pupd_host (.MCLK(MCLK), .LIST_READY(LIST_READY), .LIST_VALID(LIST_VALID),
		.LIST_LAST(LIST_LAST), .LIST_ENTRY(LIST_ENTRY), .SINGLE_VALID(SINGLE_VALID),
		.SINGLE_ENTRY(SINGLE_ENTRY));
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// sampled mid-cycle so register updates have landed
	always @(negedge MCLK) begin
		if (ACT_WE === 1'b1) got.push_back(ACT_ENTRY);
		if (ACT_COMMIT === 1'b1) n_commit++;
		if (EXPOSE_ABORT === 1'b1) n_abort++;
		if (DROP_IMAGE === 1'b1) n_drop++;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#2;
	endtask
	task automatic clr();
		got.delete();
		n_commit = 0;
		n_abort = 0;
		n_drop = 0;
	endtask
	task automatic lst(input int n, input logic [7:0] a0);
		u_pupd_host.send_list(n, a0, ok);
		if (!ok) begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic frame(input int n);
		FRAME_START = 1'b1;
		cyc(1);
		FRAME_START = 1'b0;
		cyc(n);
	endtask
	task automatic s_std_list();
		clr();
		lst(2, 8'h10);
		cyc(4);
		chk(got.size(), 0);
		chk(LIST_READY, 0);
		frame(6);
		chk(got.size(), 2);
		chk(got[0], {8'h10, 32'h0000_a000});
		chk(got[1], {8'h11, 32'h0000_a001});
		chk(n_commit, 1);
	endtask
	task automatic s_max_list();
		clr();
		lst(64, 8'h00);
		frame(70);
		chk(got.size(), 64);
		chk(LIST_OVERFLOW, 0);
		clr();
		lst(65, 8'h80);
		frame(72);
		chk(LIST_OVERFLOW, 1);
		chk(got.size(), 64);
	endtask
	task automatic s_quick_list();
		clr();
		QUICK_CHANGE_MODE = 1'b1;
		TRANSFERRING = 1'b1;
		lst(2, 8'h40);
		chk(EXPOSE_HOLD, 1);
		cyc(4);
		chk(got.size(), 0);
		EXPOSING = 1'b1;
		TRANSFERRING = 1'b0;
		cyc(6);
		EXPOSING = 1'b0;
		chk(got.size(), 2);
		chk(n_commit, 1);
		chk(n_abort, 1);
		chk(EXPOSE_HOLD, 0);
	endtask
	task automatic s_quick_single();
		clr();
		EXPOSING = 1'b1;
		TRANSFERRING = 1'b1;
		u_pupd_host.send_single(8'h20, 32'h0000_0005);
		cyc(3);
		chk(got.size(), 0);
		TRANSFERRING = 1'b0;
		cyc(4);
		EXPOSING = 1'b0;
		chk(got.size(), 1);
		chk(got[0], {8'h20, 32'h0000_0005});
		chk(n_abort, 1);
		chk(n_drop, 1);
	endtask
	task automatic s_std_single();
		clr();
		QUICK_CHANGE_MODE = 1'b0;
		u_pupd_host.send_single(8'h30, 32'h0000_0001);
		cyc(1);
		u_pupd_host.send_single(8'h30, 32'h0000_0002);
		cyc(3);
		chk(got.size(), 0);
		frame(6);
		chk(got.size(), 1);
		chk(got[0].data, 32'h0000_0002);
		chk(n_abort, 0);
	endtask
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		RST = 1'b1;
		QUICK_CHANGE_MODE = 1'b0;
		FRAME_START = 1'b0;
		EXPOSING = 1'b0;
		TRANSFERRING = 1'b0;
		repeat (2) @(posedge MCLK);
		#2;
		RST = 1'b0;
		s_std_list();
		s_max_list();
		s_quick_list();
		s_quick_single();
		s_std_single();
		results();
	end
endmodule
